// [gmio_map.svh]
// Constant map for the receiver pin-level control block.
`ifndef GMIO_MAP_SVH
`define GMIO_MAP_SVH

`define GMIO_CLK_HZ 20000000
`define GMIO_BAUD_4800 4800
`define GMIO_BAUD_9600 9600
`define GMIO_BAUD_38400 38400
`define GMIO_BAUD_115200 115200
`define GMIO_FIX_PULSE_MS 50
`define GMIO_PPS_PULSE_MS 100
`define GMIO_RTC_HZ 32768
`define GMIO_HOT_LIMIT_S 7200
`define GMIO_SENT_GGA 0
`define GMIO_SENT_GSA 1
`define GMIO_SENT_GSV 2
`define GMIO_SENT_RMC 3
`define GMIO_SENT_DEFAULT 4'hF

`endif

// [gmio_pkg.sv]
// Types shared by the receiver pin-level control block.
package gmio_pkg;

  typedef enum logic [1:0] {
    GMIO_RATE_9600,
    GMIO_RATE_4800,
    GMIO_RATE_115200,
    GMIO_RATE_38400
  } gmio_rate_t;

  typedef enum logic [1:0] {
    GMIO_START_COLD,
    GMIO_START_WARM,
    GMIO_START_HOT
  } gmio_start_t;

  typedef enum logic [1:0] {
    GMIO_TX_IDLE,
    GMIO_TX_START,
    GMIO_TX_DATA,
    GMIO_TX_STOP
  } gmio_tx_st_t;

  typedef enum logic [1:0] {
    GMIO_RX_IDLE,
    GMIO_RX_START,
    GMIO_RX_DATA,
    GMIO_RX_STOP
  } gmio_rx_st_t;

  typedef struct packed {
    gmio_rx_st_t st;
    logic [15:0] cnt;
    logic [2:0] bit_idx;
    logic [7:0] sh;
    logic [7:0] data;
    logic valid;
  } gmio_rx_state_t;

  typedef struct packed {
    logic in_rst;
    logic run;
    gmio_rate_t rate;
    logic [15:0] bitc;
    logic [24:0] sec;
    logic pps;
    logic fix;
    logic [15:0] rtc;
    logic clk32;
    logic oe;
    logic pin_q;
    logic wake;
    logic bk_valid;
    logic [15:0] out_s;
    gmio_start_t start_mode;
    logic start_p;
    logic [3:0] sent;
    gmio_tx_st_t tx_st;
    logic [7:0] tx_sh;
    logic [2:0] tx_bit;
    logic [15:0] tx_cnt;
    logic tx;
    logic tx_rdy;
  } gmio_top_state_t;

  // Strap pins read low when the host fits the pull-down.
  function automatic gmio_rate_t gmio_decode_rate(logic fast_n, logic slow_n);
    gmio_rate_t r;
    r = GMIO_RATE_9600;
    unique case ({fast_n, slow_n})
      2'b11: r = GMIO_RATE_9600;
      2'b10: r = GMIO_RATE_4800;
      2'b01: r = GMIO_RATE_115200;
      2'b00: r = GMIO_RATE_38400;
    endcase
    return r;
  endfunction

endpackage

// [gmio_uart_rx.sv]
// Serial byte receiver used for the command and correction inputs.
`timescale 1ns/1ps
`default_nettype none
module gmio_uart_rx (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic rx_in,
  input wire logic [15:0] bit_cycles_in,
  output logic [7:0] data_out,
  output logic valid_out
);
  import gmio_pkg::*;

  gmio_rx_state_t s_r;
  gmio_rx_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.valid = 1'b0;
    unique case (s_r.st)
      GMIO_RX_IDLE: begin
        if (!rx_in) begin
          s_nxt.st = GMIO_RX_START;
          s_nxt.cnt = 16'h0001;
        end
      end
      GMIO_RX_START: begin
        // A start bit that is gone by mid-bit was a glitch.
        if (s_r.cnt >= (bit_cycles_in >> 1)) begin
          s_nxt.cnt = 16'h0001;
          s_nxt.bit_idx = 3'h0;
          s_nxt.st = rx_in ? GMIO_RX_IDLE : GMIO_RX_DATA;
        end else begin
          s_nxt.cnt = s_r.cnt + 16'h0001;
        end
      end
      GMIO_RX_DATA: begin
        if (s_r.cnt >= bit_cycles_in) begin
          s_nxt.cnt = 16'h0001;
          s_nxt.sh = {rx_in, s_r.sh[7:1]};
          if (s_r.bit_idx == 3'h7) begin
            s_nxt.st = GMIO_RX_STOP;
          end else begin
            s_nxt.bit_idx = s_r.bit_idx + 3'h1;
          end
        end else begin
          s_nxt.cnt = s_r.cnt + 16'h0001;
        end
      end
      GMIO_RX_STOP: begin
        if (s_r.cnt >= bit_cycles_in) begin
          s_nxt.st = GMIO_RX_IDLE;
          // A low stop bit is a framing error and the byte is dropped.
          if (rx_in) begin
            s_nxt.data = s_r.sh;
            s_nxt.valid = 1'b1;
          end
        end else begin
          s_nxt.cnt = s_r.cnt + 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign data_out = s_r.data;
  assign valid_out = s_r.valid;
endmodule
`default_nettype wire

// [gmio_top.sv]
// Pin-level control of the receiver: reset, rate straps, ports and pulses.
`timescale 1ns/1ps
`default_nettype none
`include "gmio_map.svh"

// Contract
// - Holding the reset pin low keeps all core logic in reset.
// - The reset pin is only an input and nothing here drives it.
// - The serial rate is one of 4800, 9600, 38400 or 115200 bit/s.
// - Open straps give 9600, slow low 4800, fast low 115200, both 38400.
// - The primary port sends sentences and takes commands, the other takes corrections.
// - The fix indicator stays low whenever no fix is held.
// - With a fix the indicator gives one 50 ms high pulse each second.
// - The time pulse rises once per second at the start of the second.
// - By default the clock pin drives a 32.768 kHz clock from the timer.
// - In input mode the clock pin edge wakes the module from low power.
// - With backup present an outage resumes warm or hot by its length.
// - Without backup the start after power-up is cold.
// - The external interrupt input is ignored.
// - After reset the primary port runs at the rate the straps select, with four sentence types on.
module gmio_top #(
  parameter int CLK_HZ = `GMIO_CLK_HZ,
  parameter int SEC_CYCLES = CLK_HZ,
  parameter int FIX_CYCLES = CLK_HZ / 1000 * `GMIO_FIX_PULSE_MS,
  parameter int PPS_CYCLES = CLK_HZ / 1000 * `GMIO_PPS_PULSE_MS,
  parameter int HOT_LIMIT_S = `GMIO_HOT_LIMIT_S
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic host_reset_n_in,
  input wire logic fast_rate_strap_n_in,
  input wire logic slow_rate_strap_n_in,
  input wire logic main_supply_ok_in,
  input wire logic backup_supply_pin_in,
  input wire logic has_fix_in,
  input wire logic low_power_in,
  input wire logic clk_pin_input_mode_in,
  input wire logic rtc_clock_pin_in,
  input wire logic external_wake_irq_in,
  input wire logic [7:0] sentence_data_in,
  input wire logic sentence_valid_in,
  input wire logic primary_rx_in,
  input wire logic secondary_rx_in,
  output logic primary_tx_out,
  output logic sentence_ready_out,
  output logic [7:0] command_data_out,
  output logic command_valid_out,
  output logic [7:0] correction_data_out,
  output logic correction_valid_out,
  output logic pps_out,
  output logic fix_indicator_out,
  output logic rtc_clock_pin_out,
  output logic rtc_clock_pin_oe_out,
  output logic wake_out,
  output gmio_pkg::gmio_rate_t baud_rate_out,
  output gmio_pkg::gmio_start_t start_mode_out,
  output logic start_pulse_out,
  output logic [3:0] sentence_enable_out,
  output logic core_running_out
);
  import gmio_pkg::*;

  localparam int RTC_HALF = CLK_HZ / (2 * `GMIO_RTC_HZ);

  gmio_top_state_t s_r;
  gmio_top_state_t s_nxt;
  logic core_rst;
  logic rx_rst;
  logic [24:0] fix_hi_r;

  // Round to the nearest whole cycle per bit.
  function automatic logic [15:0] bit_cycles(gmio_rate_t r);
    int baud;
    baud = `GMIO_BAUD_9600;
    unique case (r)
      GMIO_RATE_9600: baud = `GMIO_BAUD_9600;
      GMIO_RATE_4800: baud = `GMIO_BAUD_4800;
      GMIO_RATE_115200: baud = `GMIO_BAUD_115200;
      GMIO_RATE_38400: baud = `GMIO_BAUD_38400;
    endcase
    return 16'((CLK_HZ + baud / 2) / baud);
  endfunction

  // The pin only feeds the core reset; it has no output path.
  assign core_rst = !host_reset_n_in || !main_supply_ok_in;
  assign rx_rst = srst_in || core_rst || s_r.in_rst;

  // The interrupt pin is left unread on purpose.

  always_comb begin
    s_nxt = s_r;
    s_nxt.start_p = 1'b0;
    s_nxt.wake = 1'b0;
    s_nxt.pin_q = rtc_clock_pin_in;

    // Timer side keeps running through core resets, as on backup power.
    if (s_r.rtc >= 16'(RTC_HALF - 1)) begin
      s_nxt.rtc = 16'h0000;
      s_nxt.clk32 = !s_r.clk32;
    end else begin
      s_nxt.rtc = s_r.rtc + 16'h0001;
    end
    s_nxt.oe = !clk_pin_input_mode_in;
    if (s_r.sec >= 25'(SEC_CYCLES - 1)) begin
      s_nxt.sec = 25'h0000000;
      if (core_rst && s_r.out_s != 16'hFFFF) begin
        s_nxt.out_s = s_r.out_s + 16'h0001;
      end
    end else begin
      s_nxt.sec = s_r.sec + 25'h0000001;
    end
    // Retained state survives only while the backup supply stays up.
    s_nxt.bk_valid = backup_supply_pin_in && (s_r.bk_valid || s_r.run);

    if (core_rst) begin
      s_nxt.run = 1'b0;
      s_nxt.in_rst = 1'b1;
      s_nxt.sent = `GMIO_SENT_DEFAULT;
      s_nxt.tx_st = GMIO_TX_IDLE;
      s_nxt.tx = 1'b1;
    end else if (s_r.in_rst) begin
      s_nxt.in_rst = 1'b0;
      s_nxt.run = 1'b1;
      s_nxt.rate = gmio_decode_rate(fast_rate_strap_n_in,
                                    slow_rate_strap_n_in);
      s_nxt.bitc = bit_cycles(s_nxt.rate);
      s_nxt.start_p = 1'b1;
      if (!s_r.bk_valid) begin
        s_nxt.start_mode = GMIO_START_COLD;
      end else if (s_r.out_s > 16'(HOT_LIMIT_S)) begin
        s_nxt.start_mode = GMIO_START_WARM;
      end else begin
        s_nxt.start_mode = GMIO_START_HOT;
      end
      s_nxt.out_s = 16'h0000;
    end else begin
      if (clk_pin_input_mode_in && low_power_in && rtc_clock_pin_in &&
          !s_r.pin_q) begin
        s_nxt.wake = 1'b1;
      end
      // Sentence bytes leave on the primary port, LSB first.
      unique case (s_r.tx_st)
        GMIO_TX_IDLE: begin
          if (sentence_valid_in && s_r.tx_rdy) begin
            s_nxt.tx_sh = sentence_data_in;
            s_nxt.tx = 1'b0;
            s_nxt.tx_cnt = 16'h0001;
            s_nxt.tx_st = GMIO_TX_START;
          end
        end
        GMIO_TX_START: begin
          if (s_r.tx_cnt >= s_r.bitc) begin
            s_nxt.tx_cnt = 16'h0001;
            s_nxt.tx = s_r.tx_sh[0];
            s_nxt.tx_sh = {1'b0, s_r.tx_sh[7:1]};
            s_nxt.tx_bit = 3'h0;
            s_nxt.tx_st = GMIO_TX_DATA;
          end else begin
            s_nxt.tx_cnt = s_r.tx_cnt + 16'h0001;
          end
        end
        GMIO_TX_DATA: begin
          if (s_r.tx_cnt >= s_r.bitc) begin
            s_nxt.tx_cnt = 16'h0001;
            if (s_r.tx_bit == 3'h7) begin
              s_nxt.tx = 1'b1;
              s_nxt.tx_st = GMIO_TX_STOP;
            end else begin
              s_nxt.tx = s_r.tx_sh[0];
              s_nxt.tx_sh = {1'b0, s_r.tx_sh[7:1]};
              s_nxt.tx_bit = s_r.tx_bit + 3'h1;
            end
          end else begin
            s_nxt.tx_cnt = s_r.tx_cnt + 16'h0001;
          end
        end
        GMIO_TX_STOP: begin
          if (s_r.tx_cnt >= s_r.bitc) begin
            s_nxt.tx_st = GMIO_TX_IDLE;
          end else begin
            s_nxt.tx_cnt = s_r.tx_cnt + 16'h0001;
          end
        end
      endcase
    end

    s_nxt.tx_rdy = s_nxt.run && (s_nxt.tx_st == GMIO_TX_IDLE);
    // A pulse only starts on the second boundary, so a core start or a new
    // fix part way through a second never gives a short or misplaced pulse.
    s_nxt.pps = s_nxt.run && ((s_nxt.sec == 25'h0000000) ||
                (s_r.pps && (s_nxt.sec < 25'(PPS_CYCLES))));
    // Losing the fix drops the indicator at once, even mid-pulse.
    s_nxt.fix = s_nxt.run && has_fix_in &&
                ((s_nxt.sec == 25'h0000000) ||
                 (s_r.fix && (s_nxt.sec < 25'(FIX_CYCLES))));
  end

  // Power-on reset lands at 9600 and cold; the pin reset spares the timer.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_r <= '0;
      s_r.in_rst <= 1'b1;
      s_r.rate <= GMIO_RATE_9600;
      s_r.bitc <= 16'((CLK_HZ + `GMIO_BAUD_9600 / 2) / `GMIO_BAUD_9600);
      s_r.sent <= `GMIO_SENT_DEFAULT;
      s_r.oe <= 1'b1;
      s_r.tx <= 1'b1;
      s_r.start_mode <= GMIO_START_COLD;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Command bytes arrive on the primary port, corrections on the other.
  gmio_uart_rx u_cmd_rx (
    .clk_in(clk_in),
    .srst_in(rx_rst),
    .rx_in(primary_rx_in),
    .bit_cycles_in(s_r.bitc),
    .data_out(command_data_out),
    .valid_out(command_valid_out)
  );

  gmio_uart_rx u_corr_rx (
    .clk_in(clk_in),
    .srst_in(rx_rst),
    .rx_in(secondary_rx_in),
    .bit_cycles_in(s_r.bitc),
    .data_out(correction_data_out),
    .valid_out(correction_valid_out)
  );

  assign primary_tx_out = s_r.tx;
  assign sentence_ready_out = s_r.tx_rdy;
  assign pps_out = s_r.pps;
  assign fix_indicator_out = s_r.fix;
  assign rtc_clock_pin_out = s_r.clk32;
  assign rtc_clock_pin_oe_out = s_r.oe;
  assign wake_out = s_r.wake;
  assign baud_rate_out = s_r.rate;
  assign start_mode_out = s_r.start_mode;
  assign start_pulse_out = s_r.start_p;
  assign sentence_enable_out = s_r.sent;
  assign core_running_out = s_r.run;

  // Length of the current indicator pulse, for checking only.
  always_ff @(posedge clk_in) begin
    if (srst_in || !s_r.fix) begin
      fix_hi_r <= 25'h0000000;
    end else begin
      fix_hi_r <= fix_hi_r + 25'h0000001;
    end
  end

  property p_reset_pin;
    @(posedge clk_in) disable iff (srst_in)
    !host_reset_n_in |=> !core_running_out && !sentence_ready_out &&
                         primary_tx_out;
  endproperty
  a_reset_pin: assert property (p_reset_pin)
    else $error("core still active while reset pin is low");

  property p_strap_decode;
    @(posedge clk_in) disable iff (srst_in)
    (s_r.in_rst && !core_rst) |=> baud_rate_out ==
      gmio_decode_rate($past(fast_rate_strap_n_in),
                       $past(slow_rate_strap_n_in));
  endproperty
  a_strap_decode: assert property (p_strap_decode)
    else $error("rate does not match straps at release");

  property p_rate_hold;
    @(posedge clk_in) disable iff (srst_in)
    (!core_rst && !s_r.in_rst) |=> $stable(baud_rate_out);
  endproperty
  a_rate_hold: assert property (p_rate_hold)
    else $error("rate changed outside reset release");

  property p_no_fix_low;
    @(posedge clk_in) disable iff (srst_in)
    !has_fix_in |=> !fix_indicator_out;
  endproperty
  a_no_fix_low: assert property (p_no_fix_low)
    else $error("fix indicator high without a fix");

  property p_fix_width;
    @(posedge clk_in) disable iff (srst_in)
    fix_hi_r <= 25'(FIX_CYCLES);
  endproperty
  a_fix_width: assert property (p_fix_width)
    else $error("fix indicator pulse too long");

  property p_pps_edge;
    @(posedge clk_in) disable iff (srst_in)
    $rose(pps_out) |-> s_r.sec == 25'h0000000;
  endproperty
  a_pps_edge: assert property (p_pps_edge)
    else $error("time pulse not at start of second");

  property p_clk_runs;
    @(posedge clk_in) disable iff (srst_in)
    rtc_clock_pin_oe_out |-> ##[1:400]
      ($changed(rtc_clock_pin_out) || !rtc_clock_pin_oe_out);
  endproperty
  a_clk_runs: assert property (p_clk_runs)
    else $error("clock pin stopped while driven");

  property p_wake;
    @(posedge clk_in) disable iff (srst_in)
    (core_running_out && !core_rst && clk_pin_input_mode_in &&
     low_power_in && rtc_clock_pin_in && !s_r.pin_q) |=> wake_out;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake edge on clock pin ignored");

  property p_cold;
    @(posedge clk_in) disable iff (srst_in)
    ($rose(core_running_out) && !$past(s_r.bk_valid)) |->
      start_mode_out == GMIO_START_COLD && start_pulse_out;
  endproperty
  a_cold: assert property (p_cold)
    else $error("start without backup was not cold");

  property p_retained;
    @(posedge clk_in) disable iff (srst_in)
    ($rose(core_running_out) && $past(s_r.bk_valid)) |->
      start_mode_out != GMIO_START_COLD;
  endproperty
  a_retained: assert property (p_retained)
    else $error("start with backup was cold");

  property p_tx_idle;
    @(posedge clk_in) disable iff (srst_in)
    sentence_ready_out |-> primary_tx_out;
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("primary line low while idle");
endmodule
`default_nettype wire

// [gmio_host_model.sv]
// Host-side model: reset pin, rate straps and the two serial lines.
`timescale 1ns/1ps
`default_nettype none
module gmio_host_model (
  input wire logic clk_in,
  input wire logic [15:0] bit_cycles_in,
  input wire logic primary_tx_in,
  output logic host_reset_n_out,
  output logic fast_strap_n_out,
  output logic slow_strap_n_out,
  output logic primary_rx_out,
  output logic secondary_rx_out
);
  initial begin
    host_reset_n_out = 1'b1;
    fast_strap_n_out = 1'b1;
    slow_strap_n_out = 1'b1;
    primary_rx_out = 1'b1;
    secondary_rx_out = 1'b1;
  end
  // Straps move together with the reset pin so the sample point is clean.
  task automatic pins(input logic rst_n, input logic f_n, input logic s_n);
    @(negedge clk_in);
    host_reset_n_out = rst_n;
    fast_strap_n_out = f_n;
    slow_strap_n_out = s_n;
  endtask
  // Commands go on the primary line, corrections on the secondary line.
  task automatic send(input logic sec, input logic [7:0] d);
    logic [9:0] fr;
    fr = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_in);
      if (sec) secondary_rx_out = fr[i];
      else primary_rx_out = fr[i];
      repeat (bit_cycles_in - 1) @(negedge clk_in);
    end
  endtask
  // Samples each bit near its centre; ok drops on a bad start or stop bit.
  task automatic recv(output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    d = 8'h00;
    while (primary_tx_in !== 1'b0 && n < 4000) begin
      @(negedge clk_in);
      n++;
    end
    repeat (bit_cycles_in / 2) @(negedge clk_in);
    ok = (primary_tx_in === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cycles_in) @(negedge clk_in);
      d[i] = primary_tx_in;
    end
    repeat (bit_cycles_in) @(negedge clk_in);
    ok = ok && (primary_tx_in === 1'b1);
  endtask
endmodule
`default_nettype wire

// [test_gmio_top.sv]
// Self-checking bench for the receiver pin-level control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
  end \
end
module test_gmio_top;
  import gmio_pkg::*;
  localparam int SEC = 2000;
  localparam int FIXC = 100;
  localparam int PPSC = 200;
  localparam int LIMIT = 40000;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic clk, srst, main_ok, bk, has_fix, lp, inmode, rtc_in, irq, svalid;
  logic rst_n, fast_n, slow_n, prx, srx, ptx, ready, cvalid, kvalid;
  logic pps, fix, rtc_out, oe, wake, pulse, running;
  logic [7:0] sdata, cdata, kdata;
  logic [15:0] bitc;
  logic [3:0] sent;
  gmio_rate_t rate;
  gmio_start_t mode;
  gmio_top #(.CLK_HZ(200000), .SEC_CYCLES(SEC), .FIX_CYCLES(FIXC),
    .PPS_CYCLES(PPSC), .HOT_LIMIT_S(2)) uut (
    .clk_in(clk), .srst_in(srst), .host_reset_n_in(rst_n),
    .fast_rate_strap_n_in(fast_n), .slow_rate_strap_n_in(slow_n),
    .main_supply_ok_in(main_ok), .backup_supply_pin_in(bk),
    .has_fix_in(has_fix), .low_power_in(lp),
    .clk_pin_input_mode_in(inmode), .rtc_clock_pin_in(rtc_in),
    .external_wake_irq_in(irq), .sentence_data_in(sdata),
    .sentence_valid_in(svalid), .primary_rx_in(prx),
    .secondary_rx_in(srx), .primary_tx_out(ptx),
    .sentence_ready_out(ready), .command_data_out(cdata),
    .command_valid_out(cvalid), .correction_data_out(kdata),
    .correction_valid_out(kvalid), .pps_out(pps),
    .fix_indicator_out(fix), .rtc_clock_pin_out(rtc_out),
    .rtc_clock_pin_oe_out(oe), .wake_out(wake), .baud_rate_out(rate),
    .start_mode_out(mode), .start_pulse_out(pulse),
    .sentence_enable_out(sent), .core_running_out(running));
  gmio_host_model host (.clk_in(clk), .bit_cycles_in(bitc),
    .primary_tx_in(ptx), .host_reset_n_out(rst_n),
    .fast_strap_n_out(fast_n), .slow_strap_n_out(slow_n),
    .primary_rx_out(prx), .secondary_rx_out(srx));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic give_verdict();
    if (miscompares == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic wait_start(input gmio_start_t em, input gmio_rate_t er);
    int n;
    n = 0;
    while (pulse !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    `CHK("start_pulse", 1'b1, pulse)
    `CHK("start_mode", em, mode)
    `CHK("rate", er, rate)
    `CHK("running", 1'b1, running)
  endtask
  task automatic core_reset(input logic [1:0] st, input gmio_start_t em,
    input gmio_rate_t er);
    host.pins(1'b0, st[1], st[0]);
    repeat (3) @(negedge clk);
    host.pins(1'b1, st[1], st[0]);
    wait_start(em, er);
  endtask
  task automatic t_straps();
    logic [1:0] st [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
    gmio_rate_t er [4] = '{GMIO_RATE_9600, GMIO_RATE_4800,
      GMIO_RATE_115200, GMIO_RATE_38400};
    for (int i = 0; i < 4; i++) begin
      core_reset(st[i], GMIO_START_HOT, er[i]);
      host.pins(1'b1, ~st[i][1], ~st[i][0]);
      repeat (5) @(negedge clk);
      `CHK("rate_held", er[i], rate)
    end
    core_reset(2'h3, GMIO_START_HOT, GMIO_RATE_9600);
  endtask
  task automatic tx_byte(input logic [7:0] v);
    logic [7:0] d;
    logic ok;
    int n;
    n = 0;
    fork
      host.recv(d, ok);
      begin
        @(negedge clk);
        sdata = v;
        svalid = 1'b1;
        // Ready is read at the falling edge, where it has settled.
        while (ready !== 1'b1 && n < 400) begin
          @(negedge clk);
          n++;
        end
        @(negedge clk);
        svalid = 1'b0;
        `CHK("ready_busy", 1'b0, ready)
      end
    join
    `CHK("tx_byte", v, d)
    `CHK("tx_frame", 1'b1, ok)
  endtask
  task automatic rx_chk(input logic sec, input logic [7:0] d);
    int hits;
    int wrong;
    hits = 0;
    wrong = 0;
    fork
      host.send(sec, d);
      repeat (300) begin
        @(negedge clk);
        if ((sec ? kvalid : cvalid) === 1'b1) hits++;
        if ((sec ? cvalid : kvalid) === 1'b1) wrong++;
      end
    join
    `CHK("rx_valid", 1, hits)
    `CHK("rx_wrong_port", 0, wrong)
    `CHK("rx_data", d, (sec ? kdata : cdata))
  endtask
  task automatic count_sec(output int ph, output int fh, output int rs);
    logic prev;
    ph = 0;
    fh = 0;
    rs = 0;
    prev = 1'b1;
    repeat (SEC) begin
      if (pps === 1'b1) ph++;
      if (fix === 1'b1) fh++;
      if (pps === 1'b1 && prev === 1'b0) rs++;
      prev = pps;
      @(negedge clk);
    end
  endtask
  task automatic t_pulses();
    int ph, fh, rs, n;
    n = 0;
    has_fix = 1'b1;
    while (pps !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    while (pps !== 1'b1 && n < 2400) begin
      @(negedge clk);
      n++;
    end
    count_sec(ph, fh, rs);
    `CHK("pps_width", PPSC, ph)
    `CHK("pps_extra_edge", 0, rs)
    `CHK("pps_next_second", 1'b1, pps)
    `CHK("fix_width", FIXC, fh)
    has_fix = 1'b0;
    // The registered indicator needs one edge to see the lost fix.
    @(negedge clk);
    count_sec(ph, fh, rs);
    `CHK("fix_without_fix", 0, fh)
  endtask
  task automatic wake_count(output int w);
    w = 0;
    repeat (6) begin
      @(negedge clk);
      if (wake === 1'b1) w++;
    end
  endtask
  task automatic t_clock_wake();
    int n;
    logic prev;
    n = 0;
    repeat (1000) begin
      prev = rtc_out;
      @(negedge clk);
      if (rtc_out !== prev) n++;
    end
    // About 328 edges per 1000 cycles; whole-cycle halves add a few.
    `CHK("clk_toggles", 1'b1, n >= 320 && n <= 340)
    inmode = 1'b1;
    lp = 1'b1;
    irq = 1'b1;
    wake_count(n);
    `CHK("clk_pin_oe", 1'b0, oe)
    `CHK("irq_wake", 0, n)
    irq = 1'b0;
    rtc_in = 1'b1;
    wake_count(n);
    `CHK("sensor_wake", 1, n)
    rtc_in = 1'b0;
    lp = 1'b0;
    repeat (2) @(negedge clk);
    rtc_in = 1'b1;
    wake_count(n);
    `CHK("awake_no_wake", 0, n)
    rtc_in = 1'b0;
    inmode = 1'b0;
  endtask
  task automatic t_outages();
    int bad;
    bad = 0;
    host.pins(1'b0, 1'b1, 1'b1);
    repeat (SEC + 500) begin
      @(negedge clk);
      if (pps === 1'b1 || running === 1'b1 || ready === 1'b1) bad++;
    end
    `CHK("held_in_reset", 0, bad)
    host.pins(1'b1, 1'b1, 1'b1);
    wait_start(GMIO_START_HOT, GMIO_RATE_9600);
    main_ok = 1'b0;
    repeat (4 * SEC + 100) @(negedge clk);
    main_ok = 1'b1;
    wait_start(GMIO_START_WARM, GMIO_RATE_9600);
    bk = 1'b0;
    repeat (5) @(negedge clk);
    main_ok = 1'b0;
    repeat (10) @(negedge clk);
    main_ok = 1'b1;
    wait_start(GMIO_START_COLD, GMIO_RATE_9600);
  endtask
  initial begin
    srst = 1'b1;
    main_ok = 1'b1;
    bk = 1'b1;
    has_fix = 1'b0;
    lp = 1'b0;
    inmode = 1'b0;
    rtc_in = 1'b0;
    irq = 1'b0;
    svalid = 1'b0;
    sdata = 8'h00;
    bitc = 16'h0015;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    wait_start(GMIO_START_COLD, GMIO_RATE_9600);
    `CHK("sentence_mask", 4'hF, sent)
    `CHK("clk_pin_drive", 1'b1, oe)
    t_straps();
    tx_byte(8'hA5);
    tx_byte(8'h3C);
    rx_chk(1'b0, 8'h5A);
    rx_chk(1'b1, 8'hC3);
    t_pulses();
    t_clock_wake();
    t_outages();
    give_verdict();
  end
endmodule
`default_nettype wire
